// >>> hw/spwm_pkg.sv
// package of the single channel modulator: register map, reset values, state record
// assumes an apb master with 32-bit data and byte addresses on paddr[7:0]
`default_nettype none
package spwm_pkg;
    // ************************************************
    // register byte offsets
    // ************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00; // run, load, port latch
    localparam logic [7:0] OFS_CTRL3 = 8'h04; // modulator_control_three
    localparam logic [7:0] OFS_PER_LO = 8'h08; // period_low_byte holding
    localparam logic [7:0] OFS_PER_HI = 8'h0C; // period_high_byte holding
    localparam logic [7:0] OFS_CMP_LO = 8'h10; // compare_low_byte holding
    localparam logic [7:0] OFS_CMP_HI = 8'h14; // compare_high_byte holding
    localparam logic [7:0] OFS_STATUS = 8'h18; // sticky underflow flag, write one to clear
    localparam logic [7:0] OFS_MASK = 8'h1C; // interrupt mask
    localparam logic [7:0] OFS_COUNT = 8'h20; // live counter value
    // ************************************************
    // field positions
    // ************************************************
    localparam int CTRL_RUN = 0;
    localparam int CTRL_LOAD = 1;
    localparam int CTRL_LATCH = 2;
    localparam int STAT_UF = 0;
    // ************************************************
    // values
    // ************************************************
    localparam logic [9:0] CMP_ALL_ZERO = 10'h000; // output always high
    localparam logic [9:0] CMP_ALL_ONE = 10'h3FF; // output always low
    localparam logic [9:0] RST_TEN = 10'h000; // reset of ten-bit fields
    localparam logic [1:0] RST_PRESC = 2'h0; // divide by one
    localparam logic OUT_RST = 1'b1; // internal output high after reset
    // ************************************************
    // whole state of the block
    // ************************************************
    typedef struct packed {
        logic run; // counter_run_bit
        logic load; // transfer request
        logic latch; // shared port latch bit
        logic [1:0] presc; // prescale_select
        logic [2:0] pre_cnt; // prescaler count
        logic [9:0] per_hold; // period holding
        logic [9:0] cmp_hold; // compare holding
        logic [9:0] per_act; // period_reload_value
        logic [9:0] cmp_act; // active compare
        logic [9:0] cnt; // down counter
        logic out; // channel_zero_output
        logic pin; // output_port_pin
        logic flag; // underflow_flag
        logic mask; // interrupt mask
        logic irq; // interrupt line
        logic [31:0] prdata; // read data
        logic pready; // access done
        logic pslverr; // unmapped address
    } spwm_state_t;
endpackage
`default_nettype wire

// >>> hw/spwm_top.sv
// single channel pulse width modulator with apb register access
// assumes pclk at 250 MHz, asynchronous active-low presetn, apb master on the same clock
`default_nettype none
module spwm_top
    import spwm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic channel_zero_output,
    output logic output_port_pin
);
    // ************************************************
    // state and next state
    // ************************************************
    spwm_state_t st_ff; // registered state
    spwm_state_t nxt_st; // next state
    logic tick; // one counter clock
    logic uf; // underflow on this tick
    logic acc; // apb access phase
    logic wr; // write taken this cycle
    logic [2:0] pre_top; // last prescaler count
    logic [9:0] nxt_cnt; // counter after tick
    logic [9:0] use_per; // period in force after tick
    logic [9:0] use_cmp; // compare in force after tick

    // ************************************************
    // prescaler
    // ************************************************
    // prescaler terminal count
    always_comb begin
        case (st_ff.presc)
            2'h0: pre_top = 3'h0;
            2'h1: pre_top = 3'h1;
            2'h2: pre_top = 3'h3;
            default: pre_top = 3'h7;
        endcase
    end

    // counter clock and underflow strobes; a count left above the top by a slower setting ticks at once
    assign tick = st_ff.run && (st_ff.pre_cnt >= pre_top);
    assign uf = tick && (st_ff.cnt == RST_TEN);
    assign acc = psel && penable && !st_ff.pready;
    assign wr = acc && pwrite;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        nxt_st = st_ff;
        // transfer holding to active at underflow when requested
        use_per = (uf && st_ff.load) ? st_ff.per_hold : st_ff.per_act;
        use_cmp = (uf && st_ff.load) ? st_ff.cmp_hold : st_ff.cmp_act;
        // down count, reload on underflow
        nxt_cnt = uf ? use_per : st_ff.cnt - 10'h001;
        // prescaler runs only with run set
        if (st_ff.run) begin
            nxt_st.pre_cnt = tick ? 3'h0 : st_ff.pre_cnt + 3'h1;
        end
        // counter and output step only on a counter clock, so clearing run freezes them
        if (tick) begin
            nxt_st.cnt = nxt_cnt;
            nxt_st.per_act = use_per;
            nxt_st.cmp_act = use_cmp;
            // high while count is at or above compare: period-compare+1 clocks
            nxt_st.out = (use_cmp != CMP_ALL_ONE) && (nxt_cnt >= use_cmp);
        end
        if (uf && st_ff.load) begin
            nxt_st.load = 1'b0;
        end
        // sticky flag, set wins over clear
        nxt_st.flag = st_ff.flag || uf;
        // ************************************************
        // register access
        // ************************************************
        // apb handshake: answer in the second access cycle
        nxt_st.pready = acc;
        nxt_st.pslverr = 1'b0;
        if (acc) begin
            nxt_st.prdata = 32'h0000_0000;
            if (paddr == OFS_CTRL) begin
                nxt_st.prdata[CTRL_RUN] = st_ff.run;
                nxt_st.prdata[CTRL_LOAD] = st_ff.load;
                nxt_st.prdata[CTRL_LATCH] = st_ff.latch;
                if (pwrite) begin
                    nxt_st.run = pwdata[CTRL_RUN];
                    nxt_st.load = pwdata[CTRL_LOAD] || nxt_st.load;
                    nxt_st.latch = pwdata[CTRL_LATCH];
                end
            end else if (paddr == OFS_CTRL3) begin
                nxt_st.prdata[1:0] = st_ff.presc;
                if (pwrite) begin
                    nxt_st.presc = pwdata[1:0];
                end
            end else if (paddr == OFS_PER_LO) begin
                nxt_st.prdata[7:0] = st_ff.per_hold[7:0];
                if (pwrite) begin
                    nxt_st.per_hold[7:0] = pwdata[7:0];
                end
            end else if (paddr == OFS_PER_HI) begin
                nxt_st.prdata[1:0] = st_ff.per_hold[9:8];
                if (pwrite) begin
                    nxt_st.per_hold[9:8] = pwdata[1:0];
                end
            end else if (paddr == OFS_CMP_LO) begin
                nxt_st.prdata[7:0] = st_ff.cmp_hold[7:0];
                if (pwrite) begin
                    nxt_st.cmp_hold[7:0] = pwdata[7:0];
                end
            end else if (paddr == OFS_CMP_HI) begin
                nxt_st.prdata[1:0] = st_ff.cmp_hold[9:8];
                if (pwrite) begin
                    nxt_st.cmp_hold[9:8] = pwdata[1:0];
                end
            end else if (paddr == OFS_STATUS) begin
                nxt_st.prdata[STAT_UF] = st_ff.flag;
                if (pwrite && pwdata[STAT_UF] && !uf) begin
                    nxt_st.flag = 1'b0;
                end
            end else if (paddr == OFS_MASK) begin
                nxt_st.prdata[STAT_UF] = st_ff.mask;
                if (pwrite) begin
                    nxt_st.mask = pwdata[STAT_UF];
                end
            end else if (paddr == OFS_COUNT) begin
                nxt_st.prdata[9:0] = st_ff.cnt;
            end else begin
                // unmapped: read zero, error answer
                nxt_st.pslverr = 1'b1;
            end
            // a write answer carries no data
            if (pwrite) begin
                nxt_st.prdata = 32'h0000_0000;
            end
        end
        // registered outputs from next values
        nxt_st.irq = nxt_st.flag && nxt_st.mask;
        nxt_st.pin = nxt_st.latch && nxt_st.out;
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.presc <= RST_PRESC;
            st_ff.out <= OUT_RST;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************
    // outputs, straight from the state flip-flops
    // ************************************************
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign irq = st_ff.irq;
    assign channel_zero_output = st_ff.out;
    assign output_port_pin = st_ff.pin;

    // ************************************************
    // checks
    // ************************************************
    sequence s_step;
        clk_en && tick;
    endsequence
    sequence s_uf_load;
        clk_en && uf && st_ff.load;
    endsequence
    // access cycle taken by the slave
    sequence s_access;
        clk_en && acc;
    endsequence

    // counter steps down by one on each counter clock while the count is above zero
    a_count_down: assert property (@(posedge pclk) disable iff (!presetn)
        s_step and (st_ff.cnt != RST_TEN) |=> st_ff.cnt == $past(st_ff.cnt) - 10'h001)
        else $error("counter did not step down");
    // divide by one ticks on every cycle while run is set
    a_presc_one: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.run && st_ff.presc == 2'h0 |-> tick)
        else $error("divide by one missed a tick");
    // underflow without load reloads the active period
    a_reload_per: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && uf && !st_ff.load |=> st_ff.cnt == $past(st_ff.per_act))
        else $error("reload value wrong");
    // an underflow with a reachable compare drives high
    a_high_at_uf: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && uf && !st_ff.load && st_ff.cmp_act <= st_ff.per_act && st_ff.cmp_act != CMP_ALL_ONE
        |=> st_ff.out)
        else $error("output not high after underflow");
    // all-zero compare code forces the output high
    a_zero_high: assert property (@(posedge pclk) disable iff (!presetn)
        s_step and (use_cmp == CMP_ALL_ZERO) |=> st_ff.out)
        else $error("zero compare left output low");
    // all-ones compare code forces the output low
    a_ones_low: assert property (@(posedge pclk) disable iff (!presetn)
        s_step and (use_cmp == CMP_ALL_ONE) |=> !st_ff.out)
        else $error("all ones compare left output high");
    // compare above the period never lets the output rise
    a_above_low: assert property (@(posedge pclk) disable iff (!presetn)
        s_step and (use_cmp > use_per) |=> !st_ff.out)
        else $error("compare above period left output high");
    // compare writes stop in the holding register
    a_hold_only: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr && paddr == OFS_CMP_LO && !uf |=> $stable(st_ff.cmp_act))
        else $error("compare write reached active register");
    // period writes stop in the holding register
    a_per_hold: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr && paddr == OFS_PER_HI && !uf |=> $stable(st_ff.per_act))
        else $error("period write reached active register");
    // output drops once the count passes the compare value
    a_low_at_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        s_step and (st_ff.cnt == st_ff.cmp_act) and (st_ff.cnt != RST_TEN) |=> !st_ff.out)
        else $error("output high below compare");
    // pin shows the output only with the port latch set
    a_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en ##1 1'b1 |-> st_ff.pin == ($past(nxt_st.latch) && $past(nxt_st.out)))
        else $error("pin does not follow gated output");
    // a stopped counter holds the output level
    a_freeze_out: assert property (@(posedge pclk) disable iff (!presetn)
        !st_ff.run |=> $stable(st_ff.out))
        else $error("output moved while stopped");
    // a pending load moves both holding values at underflow
    a_transfer: assert property (@(posedge pclk) disable iff (!presetn)
        s_uf_load |=> st_ff.per_act == $past(st_ff.per_hold) && st_ff.cmp_act == $past(st_ff.cmp_hold)
        && !st_ff.load && st_ff.flag)
        else $error("transfer at underflow failed");

    // ************************************************
    // register bus checks
    // ************************************************
    // a taken access is answered in the next cycle
    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        s_access |=> st_ff.pready)
        else $error("access not answered");
    // the answer lasts a single enabled cycle
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && st_ff.pready |=> !st_ff.pready)
        else $error("ready held too long");
    // addresses past the map answer with an error
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        s_access and (paddr > OFS_COUNT) |=> st_ff.pslverr)
        else $error("unmapped access without error");
    // ************************************************
    // flag, interrupt, load, counter range and enable checks
    // ************************************************
    // every underflow leaves the flag set
    a_uf_flag: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && uf |=> st_ff.flag)
        else $error("underflow did not set the flag");
    // only a status write may clear the flag
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.flag && !(wr && paddr == OFS_STATUS) |=> st_ff.flag)
        else $error("flag lost without a clear");
    // writing a one clears the flag when no underflow collides
    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr && paddr == OFS_STATUS && pwdata[STAT_UF] && !uf |=> !st_ff.flag)
        else $error("flag not cleared by write");
    // a pending load waits for an underflow
    a_load_kept: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.load && !uf |=> st_ff.load)
        else $error("load request dropped early");
    // interrupt line is the masked flag
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.irq == (st_ff.flag && st_ff.mask))
        else $error("interrupt does not match masked flag");
    // counter never sits above the period in force
    a_cnt_range: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.cnt <= st_ff.per_act)
        else $error("counter above active period");
    // a stopped counter keeps its count
    a_run_stop: assert property (@(posedge pclk) disable iff (!presetn)
        !st_ff.run |=> $stable(st_ff.cnt))
        else $error("counter moved while stopped");
    // clock enable low freezes every bit of state
    a_enable_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(st_ff))
        else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// >>> tb/spwm_load.sv
// external load on the port pin: measures high time and period of the pin
// assumes the same pclk and presetn as the modulator
`default_nettype none
module spwm_load (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic meas_v,
    output logic [15:0] hi_len,
    output logic [15:0] per_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_ff; // pin one cycle ago
    logic [15:0] hi_ff; // high cycles since last rise
    logic [15:0] per_ff; // cycles since last rise
    // a rising pin closes one period and reports it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pin_ff, hi_ff, per_ff, meas_v, hi_len, per_len} <= '0;
        end else if (pin && !pin_ff) begin
            {meas_v, hi_len, per_len} <= {1'b1, hi_ff, per_ff};
            {pin_ff, hi_ff, per_ff} <= {1'b1, 16'h0001, 16'h0001};
        end else begin
            meas_v <= 1'b0;
            {pin_ff, hi_ff, per_ff} <= {pin, hi_ff + {15'h0, pin}, per_ff + 16'h0001};
        end
    end
endmodule
`default_nettype wire

// >>> tb/spwm_tb_top.sv
// self-checking bench of the modulator: apb master, pin load model, result queues
// assumes design files under hw/ and the load model under tb/
`default_nettype none
module spwm_tb_top;
    import spwm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, chan, pin, meas_v;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] hi_len, per_len;
    logic [32:0] rq[$]; // expected {pslverr, prdata} of each access
    logic [31:0] wq[$]; // expected {high time, period} in cycles
    int err_total, comparisons, seed, p, c, k;
    int cv[3] = '{0, 1023, 7}; // compare codes that hold the level
    logic lv[3] = '{1'b1, 1'b0, 1'b0}; // level each code holds
    spwm_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .channel_zero_output(chan), .output_port_pin(pin));
    spwm_load i_load (.pclk(pclk), .presetn(presetn), .pin(pin), .meas_v(meas_v), .hi_len(hi_len),
        .per_len(per_len));
    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // one comparison, counted
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    // verdict and end of run
    task results;
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one apb transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        rq.push_back(e);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    // ten-bit value as low byte then top two bits
    task setv(input logic [7:0] a, input int v);
        apb(1'b1, a, {24'h0, v[7:0]}, 33'h0);
        apb(1'b1, a + 8'h04, {30'h0, v[9:8]}, 33'h0);
    endtask
    // skip two periods so the new setting has settled, then expect one
    task wave(input int hi, input int per);
        repeat (2) @(posedge pclk iff meas_v === 1'b1);
        @(negedge pclk);
        wq.push_back({hi[15:0], per[15:0]});
        while (wq.size() > 0) @(posedge pclk);
    endtask
    // pin must hold one level
    task lvl(input logic e);
        repeat (40) begin
            @(posedge pclk);
            chk("pin", {31'h0, e}, {31'h0, pin});
        end
    endtask
    // bus answers against oldest note
    always @(posedge pclk) if (pready === 1'b1 && rq.size() > 0) begin
        chk("prdata", rq[0][31:0], prdata);
        chk("pslverr", {31'h0, rq[0][32]}, {31'h0, pslverr});
        void'(rq.pop_front());
    end
    // measured periods against oldest note
    always @(posedge pclk) if (meas_v === 1'b1 && wq.size() > 0) begin
        chk("hi_len", {16'h0, wq[0][31:16]}, {16'h0, hi_len});
        chk("per_len", {16'h0, wq[0][15:0]}, {16'h0, per_len});
        void'(wq.pop_front());
    end
    // watchdog against hangs
    initial begin
        #200000;
        err_total++;
        results();
    end
    // main sequence
    initial begin
        {seed, err_total, comparisons} = {32'd94877, 32'd0, 32'd0};
        {presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = {5'b01000, 8'h00, 32'h0};
        repeat (5) @(posedge pclk);
        chk("chan", 32'h1, {31'h0, chan});
        chk("pin", 32'h0, {31'h0, pin});
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CTRL3, 32'h0, 33'h0);
        apb(1'b0, 8'h24, 32'h0, {1'b1, 32'h0});
        setv(OFS_PER_LO, 5);
        setv(OFS_CMP_LO, 2);
        apb(1'b0, OFS_COUNT, 32'h0, 33'h0);
        apb(1'b1, OFS_CTRL, 32'h7, 33'h0);
        wave(4, 6);
        apb(1'b0, OFS_CTRL, 32'h0, 33'h5);
        apb(1'b0, OFS_STATUS, 32'h0, 33'h1);
        setv(OFS_CMP_LO, 4);
        wave(4, 6);
        apb(1'b1, OFS_CTRL, 32'h7, 33'h0);
        wave(2, 6);
        for (k = 1; k < 4; k++) begin
            apb(1'b1, OFS_CTRL3, k, 33'h0);
            wave(2 << k, 6 << k);
        end
        apb(1'b1, OFS_CTRL3, 32'h0, 33'h0);
        repeat (3) begin
            p = 8 + ($unsigned($random(seed)) % 32);
            c = 1 + ($unsigned($random(seed)) % p);
            setv(OFS_PER_LO, p);
            setv(OFS_CMP_LO, c);
            apb(1'b1, OFS_CTRL, 32'h7, 33'h0);
            wave(p - c + 1, p + 1);
        end
        setv(OFS_PER_LO, 5);
        for (k = 0; k < 3; k++) begin
            setv(OFS_CMP_LO, cv[k]);
            apb(1'b1, OFS_CTRL, 32'h7, 33'h0);
            repeat (60) @(posedge pclk); // the longest random period must end first
            lvl(lv[k]);
        end
        // known stop level: always-high code, load, wait, then stop
        setv(OFS_CMP_LO, 0);
        apb(1'b1, OFS_CTRL, 32'h7, 33'h0);
        repeat (30) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0, 33'h5);
        apb(1'b1, OFS_CTRL, 32'h4, 33'h0);
        lvl(1'b1);
        apb(1'b1, OFS_MASK, 32'h1, 33'h0);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, OFS_STATUS, 32'h1, 33'h0);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_MASK, 32'h0, 33'h0);
        apb(1'b1, OFS_CTRL, 32'h1, 33'h0);
        // hold the block frozen for a while by its clock enable
        clk_en <= 1'b0;
        repeat (12) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        clk_en <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        chk("pin", 32'h0, {31'h0, pin});
        apb(1'b0, OFS_STATUS, 32'h0, 33'h1);
        results();
    end
endmodule
`default_nettype wire
